// ===== include/lwp_pkg.sv
// Constants and state types for the LED PWM intensity block.
// Assumes a single 40 MHz clock and a decoded byte-wide register port.
//
// Behaviour
// - Master nibble zero: every output static at its phase bit, no PWM.
// - Master nonzero, global off: each output uses its own 4-bit setting.
// - Setting n from 0 to 14 gives n+1 sixteenths active per gated slot.
// - Setting 15 is static: low for phase 0, high impedance for phase 1.
// - Master nonzero, global set: ninth nibble drives all outputs.
// - Phase 0: low for n+1 sixteenths, high for the rest.
// - Phase 1: low for 15-n sixteenths, high impedance for n+1.
// - Period of 240 steps: 15 slots of 16 cycles each.
// - Master nibble gates PWM to 1..15 slots; individual settings 0..14 act only there.
// - Ninth output nibble doubles as the global setting.
// - Phase bit 1 leaves pin released, 0 pulls low, during active time.
package lwp_pkg;
    localparam int NUM_PORT = 8;
    localparam int NUM_OUT = 9;
    localparam int REG_W = 8;
    localparam int NUM_REGS = 7;
    localparam int IDX_W = 3;
    localparam int DIV_W = 12;

    // Register offsets
    localparam logic [7:0] ADDR_PHASE = 8'h02;
    localparam logic [7:0] ADDR_MASTER = 8'h0e;
    localparam logic [7:0] ADDR_CFG = 8'h0f;
    localparam logic [7:0] ADDR_INT0 = 8'h10;
    localparam logic [7:0] ADDR_INT3 = 8'h13;

    // Storage indices
    localparam logic [2:0] IDX_PHASE = 3'h0;
    localparam logic [2:0] IDX_MASTER = 3'h1;
    localparam logic [2:0] IDX_CFG = 3'h2;
    localparam logic [2:0] IDX_INT0 = 3'h3;

    // Field positions
    localparam int MASTER_LSB = 4;
    localparam int NINTH_LSB = 0;
    localparam int CFG_NINTH_PHASE_BIT = 0;
    localparam int CFG_GLOBAL_BIT = 1;

    // Reset values
    localparam logic [7:0] RST_PHASE = 8'hff;
    localparam logic [7:0] RST_MASTER = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h01;
    localparam logic [7:0] RST_INT = 8'hff;

    // Intensity encodings and period shape
    localparam logic [3:0] LEVEL_STATIC = 4'hf;
    localparam logic [3:0] CYC_LAST = 4'hf;
    localparam logic [3:0] SLOT_LAST = 4'he;

    // PWM step rate from the 32 kHz oscillator; longest step rounds down
    localparam int OSC_HZ = 32000;
    localparam int CLK_HZ = 40000000;
    localparam int STEP_CYC = CLK_HZ / OSC_HZ;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [3:0] cyc;
        logic [3:0] slot;
        logic [NUM_OUT-1:0] pull_low;
        logic pin_lvl;
        logic rvalid;
    } lwp_state_t;
endpackage

// ===== hw/lwp_regs.sv
// Small register store for the PWM block: all words visible in parallel.
// Assumes the caller decodes addresses to indices and flags unmapped reads.
`timescale 1ns/1ps
module lwp_regs #(
    parameter int N = 7,
    parameter int W = 8,
    parameter int IW = 3,
    parameter logic [N*W-1:0] RESET = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write side
    input wire logic wr_i,
    input wire logic [IW-1:0] widx_i,
    input wire logic [W-1:0] wdata_i,
    // Read side
    input wire logic rd_i,
    input wire logic rd_hit_i,
    input wire logic [IW-1:0] ridx_i,
    output logic [W-1:0] rdata_o,
    output logic [N*W-1:0] words_o
);
    typedef struct packed {
        logic [N-1:0][W-1:0] mem;
        logic [W-1:0] rdata;
    } lwp_mem_t;

    lwp_mem_t st;
    lwp_mem_t next_st;

    always_comb begin
        next_st = st;
        for (int i = 0; i < N; i++) begin
            if (wr_i && widx_i == IW'(i)) begin
                next_st.mem[i] = wdata_i;
            end
        end
        if (rd_i) begin
            // Unmapped offsets read as zero
            next_st.rdata = rd_hit_i ? st.mem[ridx_i] : '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.mem <= RESET;
            st.rdata <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign words_o = st.mem;
endmodule

// ===== hw/lwp_core.sv
// PWM intensity engine for eight port outputs and the ninth output.
// Assumes the serial front end hands over decoded byte register accesses
// and that pins are open drain, resolved from the enables outside.
`timescale 1ns/1ps
module lwp_core
    import lwp_pkg::*;
#(
    parameter int STEP_DIV = lwp_pkg::STEP_CYC
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [lwp_pkg::REG_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [lwp_pkg::REG_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Open-drain pins, enable high pulls low
    output logic [lwp_pkg::NUM_PORT-1:0] port_outputs_o,
    output logic [lwp_pkg::NUM_PORT-1:0] port_outputs_oe_o,
    output logic ninth_output_o,
    output logic ninth_output_oe_o
);
    import lwp_pkg::*;

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);
    localparam logic [NUM_REGS*REG_W-1:0] REG_RESET =
        {RST_INT, RST_INT, RST_INT, RST_INT, RST_CFG, RST_MASTER, RST_PHASE};

    lwp_state_t st;
    lwp_state_t next_st;

    logic [NUM_REGS*REG_W-1:0] words;
    logic hit;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] phase_reg;
    logic [REG_W-1:0] master_reg;
    logic [REG_W-1:0] cfg_reg;
    logic [3:0] master_lvl;
    logic [3:0] ninth_lvl;
    logic global_sel;
    logic [NUM_OUT-1:0] phase;
    logic [NUM_OUT-1:0][3:0] own_lvl;
    logic step;

    // Address decode to storage index
    always_comb begin
        hit = 1'b1;
        idx = '0;
        if (reg_addr_i == ADDR_PHASE) begin
            idx = IDX_PHASE;
        end else if (reg_addr_i == ADDR_MASTER) begin
            idx = IDX_MASTER;
        end else if (reg_addr_i == ADDR_CFG) begin
            idx = IDX_CFG;
        end else if (reg_addr_i >= ADDR_INT0 && reg_addr_i <= ADDR_INT3) begin
            idx = IDX_INT0 + IDX_W'(reg_addr_i - ADDR_INT0);
        end else begin
            hit = 1'b0;
        end
    end

    lwp_regs #(
        .N(NUM_REGS),
        .W(REG_W),
        .IW(IDX_W),
        .RESET(REG_RESET)
    ) u_regs (
        .clk_i(mclk_i),
        .rst_i(sys_rst_i),
        .wr_i(reg_wr_i && hit),
        .widx_i(idx),
        .wdata_i(reg_wdata_i),
        .rd_i(reg_rd_i),
        .rd_hit_i(hit),
        .ridx_i(idx),
        .rdata_o(reg_rdata_o),
        .words_o(words)
    );

    assign phase_reg = words[IDX_PHASE*REG_W +: REG_W];
    assign master_reg = words[IDX_MASTER*REG_W +: REG_W];
    assign cfg_reg = words[IDX_CFG*REG_W +: REG_W];
    assign master_lvl = master_reg[MASTER_LSB +: 4];
    assign ninth_lvl = master_reg[NINTH_LSB +: 4];
    assign global_sel = cfg_reg[CFG_GLOBAL_BIT];
    assign phase = {cfg_reg[CFG_NINTH_PHASE_BIT], phase_reg};
    assign step = (st.div == DIV_LAST);

    // Two ports share each intensity byte, low nibble first
    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            own_lvl[i] = ninth_lvl;
        end
        for (int i = 0; i < NUM_PORT; i++) begin
            own_lvl[i] = words[(IDX_INT0 + i / 2) * REG_W + (i % 2) * 4 +: 4];
        end
    end

    always_comb begin
        logic [3:0] lvl;
        logic gated;
        lvl = '0;
        gated = 1'b0;
        next_st = st;
        next_st.rvalid = reg_rd_i;
        // Step counter models the oscillator tick
        if (step) begin
            next_st.div = '0;
            if (st.cyc == CYC_LAST) begin
                next_st.cyc = '0;
                next_st.slot = (st.slot == SLOT_LAST) ? 4'h0 : st.slot + 4'h1;
            end else begin
                next_st.cyc = st.cyc + 4'h1;
            end
        end else begin
            next_st.div = st.div + DIV_W'(1);
        end
        // Slots below the master count carry PWM
        gated = (st.slot < master_lvl);
        for (int i = 0; i < NUM_OUT; i++) begin
            lvl = global_sel ? ninth_lvl : own_lvl[i];
            if (master_lvl == 4'h0 || lvl == LEVEL_STATIC) begin
                next_st.pull_low[i] = ~phase[i];
            end else if (gated && st.cyc <= lvl) begin
                // Active time from first cycle of the slot
                next_st.pull_low[i] = ~phase[i];
            end else begin
                next_st.pull_low[i] = phase[i];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rvalid_o = st.rvalid;
    assign port_outputs_o = {NUM_PORT{st.pin_lvl}};
    assign port_outputs_oe_o = st.pull_low[NUM_PORT-1:0];
    assign ninth_output_o = st.pin_lvl;
    assign ninth_output_oe_o = st.pull_low[NUM_OUT-1];

    // Checks
    property p_master_static;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (master_lvl == 4'h0) |=> (port_outputs_oe_o == ~$past(phase_reg));
    endproperty
    a_master_static: assert property (p_master_static)
        else $error("master zero did not give static outputs");

    property p_own_static;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (master_lvl != 4'h0 && !global_sel && own_lvl[0] == LEVEL_STATIC)
        |=> (port_outputs_oe_o[0] == !$past(phase_reg[0]));
    endproperty
    a_own_static: assert property (p_own_static)
        else $error("setting 15 did not give static output");

    property p_own_active;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (master_lvl != 4'h0 && !global_sel && own_lvl[1] != LEVEL_STATIC &&
         st.slot < master_lvl && st.cyc <= own_lvl[1])
        |=> (port_outputs_oe_o[1] == !$past(phase_reg[1]));
    endproperty
    a_own_active: assert property (p_own_active)
        else $error("individual active time wrong");

    property p_phase0_idle_high;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (master_lvl != 4'h0 && !global_sel && !phase_reg[0] &&
         own_lvl[0] != LEVEL_STATIC && st.cyc > own_lvl[0])
        |=> !port_outputs_oe_o[0];
    endproperty
    a_phase0_idle_high: assert property (p_phase0_idle_high)
        else $error("phase 0 output low outside active time");

    property p_phase1_idle_low;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (master_lvl != 4'h0 && !global_sel && phase_reg[2] &&
         own_lvl[2] != LEVEL_STATIC && st.cyc > own_lvl[2])
        |=> port_outputs_oe_o[2];
    endproperty
    a_phase1_idle_low: assert property (p_phase1_idle_low)
        else $error("phase 1 output not low outside active time");

    property p_gate_off;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (master_lvl != 4'h0 && !global_sel && st.slot >= master_lvl &&
         own_lvl[3] != LEVEL_STATIC)
        |=> (port_outputs_oe_o[3] == $past(phase_reg[3]));
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("PWM active outside gated slots");

    property p_global;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (master_lvl != 4'h0 && global_sel && ninth_lvl != LEVEL_STATIC &&
         st.slot < master_lvl && st.cyc <= ninth_lvl)
        |=> (port_outputs_oe_o == ~$past(phase_reg));
    endproperty
    a_global: assert property (p_global)
        else $error("global setting not applied to ports");

    property p_ninth_global;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (master_lvl != 4'h0 && ninth_lvl == LEVEL_STATIC)
        |=> (ninth_output_oe_o == !$past(cfg_reg[CFG_NINTH_PHASE_BIT]));
    endproperty
    a_ninth_global: assert property (p_ninth_global)
        else $error("ninth nibble not static at 15");

    property p_wrap;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (step && st.cyc == CYC_LAST && st.slot == SLOT_LAST)
        |=> (st.cyc == 4'h0 && st.slot == 4'h0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("period did not wrap after 240 steps");

    property p_step_only;
        @(posedge mclk_i) disable iff (sys_rst_i)
        $changed(port_outputs_oe_o) |->
            ($past(step, 2) || $past(reg_wr_i, 2) || $past(sys_rst_i, 2));
    endproperty
    a_step_only: assert property (p_step_only)
        else $error("output changed between oscillator steps");
endmodule

// ===== verif/lwp_load.sv
// Pull-up loads tied to the nine open-drain outputs.
// Assumes enable high means the block sinks the pin to its drive value.
`timescale 1ns/1ps
module lwp_load (
    // Drive and enable from the block
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    input wire logic ninth_drv_i,
    input wire logic ninth_oe_i,
    // Resolved pin levels
    output logic [7:0] pin_o,
    output logic ninth_pin_o
);
    // Released pins float up through the resistor, never hold old level
    assign pin_o = (oe_i & drv_i) | ~oe_i;
    assign ninth_pin_o = ninth_oe_i ? ninth_drv_i : 1'b1;
endmodule

// ===== verif/tb_led_pwm_intensity_control.sv
// Self-checking bench for the PWM core: register port and pin duty.
// Assumes the core, its package and the pull-up load model are compiled.
`timescale 1ns/1ps
module tb_led_pwm_intensity_control;
    import lwp_pkg::*;
    localparam int SD = 2;
    localparam int PER = 240 * SD;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic [7:0] po;
    logic [7:0] poe;
    logic [7:0] pin;
    logic no;
    logic noe;
    logic npin;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int comparisons = 0;
    int seed = 69731;

    always #12.5 mclk_i = ~mclk_i;

    lwp_core #(.STEP_DIV(SD)) i_lwp_core (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .port_outputs_o(po), .port_outputs_oe_o(poe),
        .ninth_output_o(no), .ninth_output_oe_o(noe));
    lwp_load i_lwp_load (.drv_i(po), .oe_i(poe), .ninth_drv_i(no),
        .ninth_oe_i(noe), .pin_o(pin), .ninth_pin_o(npin));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk_byte(input string n, input logic [7:0] e,
                            input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_cnt(input string n, input int e, input int g);
        comparisons++;
        if (g != e) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        exp_q.push_back(e);
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
    endtask

    // Read answers matched in order; a spare valid is a fault too
    always @(negedge mclk_i) begin
        if (reg_rvalid_o === 1'b1) begin
            if (exp_q.size() > 0) chk_byte("rdata", exp_q.pop_front(),
                                           reg_rdata_o);
            else chk_byte("spare rvalid", 8'h00, 8'hff);
        end
    end

    // Low steps per period, scaled to clocks
    function automatic int exp_low(input logic [3:0] m, input logic [3:0] l,
                                   input logic ph);
        int act;
        if (m == 4'h0 || l == LEVEL_STATIC) act = 240;
        else act = int'(m) * (int'(l) + 1);
        return (ph ? 240 - act : act) * SD;
    endfunction

    task automatic run_cfg(input logic [7:0] mw, input logic [1:0] cf,
                           input logic [7:0] ph, input logic [31:0] iv);
        int c[9];
        logic [3:0] l;
        wr(ADDR_PHASE, ph);
        wr(ADDR_MASTER, mw);
        wr(ADDR_CFG, {6'h00, cf});
        for (int k = 0; k < 4; k++) wr(ADDR_INT0 + 8'(k), iv[8*k +: 8]);
        for (int k = 0; k < 4; k++) rd(ADDR_INT0 + 8'(k), iv[8*k +: 8]);
        rd(ADDR_MASTER, mw);
        repeat (4) @(negedge mclk_i);
        c = '{default: 0};
        repeat (PER) begin
            @(negedge mclk_i);
            for (int k = 0; k < 8; k++) c[k] += int'(pin[k] === 1'b0);
            c[8] += int'(npin === 1'b0);
        end
        for (int k = 0; k < 8; k++) begin
            l = cf[CFG_GLOBAL_BIT] ? mw[3:0] : iv[4*k +: 4];
            chk_cnt("port low", exp_low(mw[7:4], l, ph[k]), c[k]);
        end
        chk_cnt("ninth low", exp_low(mw[7:4], mw[3:0], cf[0]), c[8]);
        $display("config %h %h done", mw, cf);
    endtask

    initial begin
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        sys_rst_i = 1'b0;
        rd(ADDR_PHASE, RST_PHASE);
        rd(ADDR_MASTER, RST_MASTER);
        rd(ADDR_CFG, RST_CFG);
        rd(ADDR_INT3, RST_INT);
        wr(8'h05, 8'h5a);
        rd(8'h05, 8'h00);
        $display("register reset test done");
        // Every setting code, master from zero up; global toggles
        for (int n = 0; n < 16; n++)
            run_cfg({4'(n), 4'(15 - n)}, 2'(n), 8'($random(seed)),
                    {8{4'(n)}});
        // Settings mixed per output; the sweep never reaches these
        run_cfg(8'h7f, 2'b01, 8'($random(seed)), 32'hd79a5e0f);
        run_cfg(8'hf3, 2'b00, 8'($random(seed)), 32'h0e0e0e0e);
        run_cfg(8'h0a, 2'b10, 8'($random(seed)), 32'h12345678);
        repeat (3)
            run_cfg(8'($random(seed)), 2'($random(seed)),
                    8'($random(seed)), 32'($random(seed)));
        // A read that never answered leaves its note behind
        chk_cnt("reads unanswered", 0, exp_q.size());
        stop_test();
    end

    initial begin
        #1000000;
        mismatches++;
        stop_test();
    end
endmodule
